/* File: rtl/rrn_core.sv */
// rotate right without carry: decode, file addressing, execute and wishbone registers
// Operation
// - the operand is rotated one place toward bit 0, old bit 0 lands in bit 7, only negative and zero change.
// - with the destination bit 0 the result goes to the working register and the file byte is untouched.
// - with the destination bit 1 the result is written back into the addressed file byte.
// - with the bank-mode bit 0 the bank select is ignored and, outside the indexed case below, the address lies in the access bank.
// - with the bank-mode bit 1 the address is the bank select joined with the 8-bit operand.
// - with extended set on, bank-mode 0 and operand up to 95 the address is index base plus operand.
// - every operand value 0 to 255 and both values of each option bit are accepted.
`timescale 1ns/1ps
module rrn_core
	import rrn_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// rotate one place toward bit 0 with no carry
	function automatic logic [7:0] rot_right(input logic [7:0] v);
		rot_right = {v[0], v[7:1]};
	endfunction : rot_right

	// byte lanes with sel set take new data
	function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
		begin
			merge_sel[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction : merge_sel

	logic [7:0] file_mem [0:4095];
	rrn_state_t state, next_state;
	logic [15:0] instr, next_instr;
	logic [3:0] bank_select_register, next_bank_select_register;
	logic [7:0] wreg, next_wreg;
	logic [11:0] index_base, next_index_base;
	logic [11:0] maddr, next_maddr;
	logic ext_en, next_ext_en;
	logic done, next_done;
	logic illegal, next_illegal;
	logic neg, next_neg;
	logic zero, next_zero;
	logic [11:0] addr, next_addr;
	logic [7:0] opnd, next_opnd;
	logic [7:0] result, next_result;
	logic dest_w, next_dest_w;
	logic [31:0] next_dat;
	logic next_ack;
	logic mem_we;
	logic [11:0] mem_wa;
	logic [7:0] mem_wd;
	logic start;
	logic q_tick;
	logic busy;
	logic bus_req;
	logic bus_wr;
	logic [31:0] rd_word;
	logic [31:0] wv;
	logic [7:0] f_op;
	logic a_bit;
	logic [7:0] mem_at_addr;

	assign busy = (state != RRN_IDLE);
	assign f_op = instr[7:0];
	assign a_bit = instr[RRN_A_BIT];
	assign mem_at_addr = file_mem[addr];

	// quarter phase strobes
	rrn_qphase u_qphase (
		.sys_clk(sys_clk),
		.reset(reset),
		.run(busy),
		.restart(start),
		.q_tick(q_tick)
	);

	// readback mux; unmapped offsets read zero
	always_comb
	begin
		bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		bus_wr = bus_req && wb_we_i;
		rd_word = 32'h0;
		if (wb_adr_i == RRN_OFS_CTRL)
			rd_word[RRN_CTRL_EXT] = ext_en;
		else if (wb_adr_i == RRN_OFS_INSTR)
			rd_word[15:0] = instr;
		else if (wb_adr_i == RRN_OFS_BANK)
			rd_word[3:0] = bank_select_register;
		else if (wb_adr_i == RRN_OFS_WREG)
			rd_word[7:0] = wreg;
		else if (wb_adr_i == RRN_OFS_INDEX)
			rd_word[11:0] = index_base;
		else if (wb_adr_i == RRN_OFS_STATUS)
			rd_word[4:0] = {zero, neg, illegal, done, busy};
		else if (wb_adr_i == RRN_OFS_MADDR)
			rd_word[11:0] = maddr;
		else if (wb_adr_i == RRN_OFS_MDATA)
			rd_word[7:0] = file_mem[maddr];
		wv = merge_sel(rd_word, wb_dat_i, wb_sel_i);
	end

	// bus writes, then the execution sequence; hardware sets win over clears
	always_comb
	begin
		next_state = state;
		next_instr = instr;
		next_bank_select_register = bank_select_register;
		next_wreg = wreg;
		next_index_base = index_base;
		next_maddr = maddr;
		next_ext_en = ext_en;
		next_done = done;
		next_illegal = illegal;
		next_neg = neg;
		next_zero = zero;
		next_addr = addr;
		next_opnd = opnd;
		next_result = result;
		next_dest_w = dest_w;
		next_ack = bus_req;
		next_dat = bus_req ? rd_word : 32'h0;
		mem_we = 1'b0;
		mem_wa = maddr;
		mem_wd = wv[7:0];
		start = 1'b0;
		// setup writes are locked while busy so the operands stay stable
		if (bus_wr && !busy)
		begin
			if (wb_adr_i == RRN_OFS_CTRL)
			begin
				next_ext_en = wv[RRN_CTRL_EXT];
				start = wv[RRN_CTRL_GO];
			end
			else if (wb_adr_i == RRN_OFS_INSTR)
				next_instr = wv[15:0];
			else if (wb_adr_i == RRN_OFS_BANK)
				next_bank_select_register = wv[3:0];
			else if (wb_adr_i == RRN_OFS_WREG)
				next_wreg = wv[7:0];
			else if (wb_adr_i == RRN_OFS_INDEX)
				next_index_base = wv[11:0];
			else if (wb_adr_i == RRN_OFS_MADDR)
				next_maddr = wv[11:0];
			else if (wb_adr_i == RRN_OFS_MDATA)
				mem_we = 1'b1;
		end
		// write one to clear done and illegal
		if (bus_wr && wb_adr_i == RRN_OFS_STATUS)
		begin
			if (wv[RRN_ST_DONE])
				next_done = 1'b0;
			if (wv[RRN_ST_ILLEGAL])
				next_illegal = 1'b0;
		end
		case (state)
			RRN_IDLE:
			begin
				if (start)
				begin
					next_state = RRN_DECODE;
					next_illegal = 1'b0;
				end
			end
			RRN_DECODE:
			begin
				if (q_tick)
				begin
					// any f and any d/a pair is legal once the opcode matches
					if (instr[15:10] == RRN_OPCODE)
					begin
						next_state = RRN_READ;
						next_dest_w = !instr[RRN_D_BIT];
						if (!a_bit && ext_en && f_op <= RRN_ILO_LIMIT)
							next_addr = index_base + {4'h0, f_op};
						else if (!a_bit)
							next_addr = {(f_op < RRN_ACCESS_SPLIT) ? RRN_ACCESS_LO_BANK : RRN_ACCESS_HI_BANK,
								f_op};
						else
							next_addr = {bank_select_register, f_op};
					end
					else
					begin
						next_state = RRN_IDLE;
						next_illegal = 1'b1;
					end
				end
			end
			RRN_READ:
			begin
				if (q_tick)
				begin
					next_opnd = file_mem[addr];
					next_state = RRN_PROCESS;
				end
			end
			RRN_PROCESS:
			begin
				if (q_tick)
				begin
					// carry is never touched
					next_result = rot_right(opnd);
					next_neg = opnd[0];
					next_zero = (opnd == 8'h00);
					next_state = RRN_WRITE;
				end
			end
			RRN_WRITE:
			begin
				if (q_tick)
				begin
					if (dest_w)
						next_wreg = result;
					else
					begin
						mem_we = 1'b1;
						mem_wa = addr;
						mem_wd = result;
					end
					next_done = 1'b1;
					next_state = RRN_IDLE;
				end
			end
			default:
				next_state = RRN_IDLE;
		endcase
	end

	// file memory has no reset, like real data ram
	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			file_mem[mem_wa] <= mem_wd;
	end

	// state registers
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state <= RRN_IDLE;
			instr <= RRN_INSTR_RST;
			bank_select_register <= RRN_BANK_RST;
			wreg <= RRN_BYTE_RST;
			index_base <= RRN_ADDR_RST;
			maddr <= RRN_ADDR_RST;
			ext_en <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			neg <= 1'b0;
			zero <= 1'b0;
			addr <= RRN_ADDR_RST;
			opnd <= RRN_BYTE_RST;
			result <= RRN_BYTE_RST;
			dest_w <= 1'b0;
			wb_dat_o <= 32'h0;
			wb_ack_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			instr <= next_instr;
			bank_select_register <= next_bank_select_register;
			wreg <= next_wreg;
			index_base <= next_index_base;
			maddr <= next_maddr;
			ext_en <= next_ext_en;
			done <= next_done;
			illegal <= next_illegal;
			neg <= next_neg;
			zero <= next_zero;
			addr <= next_addr;
			opnd <= next_opnd;
			result <= next_result;
			dest_w <= next_dest_w;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_decode_ok;
		state == RRN_DECODE && q_tick && instr[15:10] == RRN_OPCODE;
	endsequence
	sequence s_phases;
		state == RRN_READ [*4] ##1 state == RRN_PROCESS [*4] ##1 state == RRN_WRITE [*4] ##1 state == RRN_IDLE;
	endsequence

	property p_rotate;
		state == RRN_WRITE |-> result == {opnd[0], opnd[7:1]} && neg == result[7] && zero == (result == 8'h00);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate result or flags wrong");

	property p_dest_w;
		state == RRN_WRITE && q_tick && dest_w |=> wreg == $past(result) && mem_at_addr == $past(mem_at_addr);
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("working register destination wrong");

	property p_dest_f;
		state == RRN_WRITE && q_tick && !dest_w |=> mem_at_addr == $past(result) && $stable(wreg);
	endproperty
	a_dest_f: assert property (p_dest_f) else $error("file destination wrong");

	property p_access;
		s_decode_ok and (!a_bit && !(ext_en && f_op <= RRN_ILO_LIMIT)) |=>
			addr == {($past(f_op) < RRN_ACCESS_SPLIT) ? RRN_ACCESS_LO_BANK : RRN_ACCESS_HI_BANK, $past(f_op)};
	endproperty
	a_access: assert property (p_access) else $error("access bank address wrong");

	property p_banked;
		s_decode_ok and a_bit |=> addr == {$past(bank_select_register), $past(f_op)};
	endproperty
	a_banked: assert property (p_banked) else $error("banked address wrong");

	property p_indexed;
		s_decode_ok and (!a_bit && ext_en && f_op <= RRN_ILO_LIMIT) |=>
			addr == $past(index_base) + {4'h0, $past(f_op)};
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed literal offset address wrong");

	property p_accept;
		s_decode_ok |=> state == RRN_READ && !illegal;
	endproperty
	a_accept: assert property (p_accept) else $error("valid operand refused");

	property p_phases;
		s_decode_ok |=> s_phases;
	endproperty
	a_phases: assert property (p_phases) else $error("quarter phase sequence broken");
endmodule : rrn_core

/* File: rtl/rrn_pkg.sv */
// constants for the rotate-right-no-carry execution block
package rrn_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] RRN_OFS_CTRL = 8'h00;
	localparam logic [7:0] RRN_OFS_INSTR = 8'h04;
	localparam logic [7:0] RRN_OFS_BANK = 8'h08;
	localparam logic [7:0] RRN_OFS_WREG = 8'h0c;
	localparam logic [7:0] RRN_OFS_INDEX = 8'h10;
	localparam logic [7:0] RRN_OFS_STATUS = 8'h14;
	localparam logic [7:0] RRN_OFS_MADDR = 8'h18;
	localparam logic [7:0] RRN_OFS_MDATA = 8'h1c;
	// control bit positions
	localparam int RRN_CTRL_GO = 0;
	localparam int RRN_CTRL_EXT = 1;
	// status bit positions
	localparam int RRN_ST_BUSY = 0;
	localparam int RRN_ST_DONE = 1;
	localparam int RRN_ST_ILLEGAL = 2;
	localparam int RRN_ST_NEG = 3;
	localparam int RRN_ST_ZERO = 4;
	// instruction encoding 0100 00da ffff ffff
	localparam logic [5:0] RRN_OPCODE = 6'h10;
	localparam int RRN_D_BIT = 9;
	localparam int RRN_A_BIT = 8;
	// access bank split and indexed literal offset limit
	localparam logic [7:0] RRN_ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] RRN_ILO_LIMIT = 8'h5f;
	localparam logic [3:0] RRN_ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] RRN_ACCESS_HI_BANK = 4'hf;
	// last divider count; a quarter phase is four sys_clk cycles
	localparam logic [1:0] RRN_QDIV_LAST = 2'h3;
	// reset values
	localparam logic [15:0] RRN_INSTR_RST = 16'h0000;
	localparam logic [3:0] RRN_BANK_RST = 4'h0;
	localparam logic [7:0] RRN_BYTE_RST = 8'h00;
	localparam logic [11:0] RRN_ADDR_RST = 12'h000;
	// execution states: idle, then one per quarter phase
	typedef enum logic [2:0] {RRN_IDLE, RRN_DECODE, RRN_READ, RRN_PROCESS, RRN_WRITE} rrn_state_t;
endpackage : rrn_pkg

/* File: rtl/rrn_qphase.sv */
// quarter-phase tick divider for the execution sequence
`timescale 1ns/1ps
module rrn_qphase
	import rrn_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// control
	input wire logic run,
	input wire logic restart,
	// phase end strobe
	output logic q_tick
);
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic next_tick;

	// restart preloads one count: the start edge itself is the first decode cycle, so decode lasts four too
	always_comb
	begin
		next_cnt = cnt;
		next_tick = 1'b0;
		if (restart)
		begin
			next_cnt = 2'h1;
		end
		else if (!run)
		begin
			next_cnt = 2'h0;
		end
		else
		begin
			next_cnt = cnt + 2'h1;
			next_tick = (cnt == RRN_QDIV_LAST);
		end
	end

	// registers
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			cnt <= 2'h0;
			q_tick <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			q_tick <= next_tick;
		end
	end
endmodule : rrn_qphase

/* File: tb/rrn_bench.sv */
// self-checking bench for the rotate-right-no-carry execution block
`timescale 1ns/1ps
module rotate_right_no_carry_exec_bench
	import rrn_pkg::*;
;
	// clock and reset
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	// wishbone master signals
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [3:0] sel_mask = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	// scoreboard and model flags
	int fails = 0;
	int n_tests = 0;
	int flags = 0;
	int f_tab[$] = '{8'h00, 8'h5f, 8'h60, 8'hff, 8'h5f, 8'h60};

	rrn_core i_rrn_core (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	// 25 ns period
	always #12.5 sys_clk = ~sys_clk;

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one classic cycle; no fixed latency assumed, the watchdog ends a hang
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel_mask;
		wb_dat_i <= dat;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge sys_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask : wb_xfer

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] unused;
		wb_xfer(1'b1, adr, dat, unused);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] v;
		wb_xfer(1'b0, adr, 32'h0, v);
		check(name, v, exp);
	endtask : rd_chk

	// load operands, run one instruction and compare against the integer model
	task automatic run_op(input int ins, input int ext, input int bank, input int idx, input int wreg, input int fb);
		int f;
		int d;
		int a;
		int adr;
		int res;
		int lgl;
		logic [31:0] v;
		f = ins & 255;
		d = (ins >> 9) & 1;
		a = (ins >> 8) & 1;
		lgl = ((ins >> 10) == 16);
		if (a == 1)
			adr = bank * 256 + f;
		else if (ext == 1 && f <= 95)
			adr = (idx + f) % 4096;
		else
			adr = (f < 96) ? f : 3840 + f;
		res = ((fb >> 1) | (fb << 7)) & 255;
		wr(RRN_OFS_BANK, bank);
		wr(RRN_OFS_INDEX, idx);
		wr(RRN_OFS_WREG, wreg);
		wr(RRN_OFS_MADDR, adr);
		wr(RRN_OFS_MDATA, fb);
		wr(RRN_OFS_INSTR, ins);
		wr(RRN_OFS_STATUS, 6);
		wr(RRN_OFS_CTRL, ext * 2 + 1);
		wb_xfer(1'b0, RRN_OFS_STATUS, 32'h0, v);
		check("busy", v[0], 1'b1);
		// dropped during a legal run; a refused word is idle again by then, so the write lands
		wr(RRN_OFS_WREG, wreg ^ 255);
		for (int k = 0; k < 20 && v[0] !== 1'b0; k++)
			wb_xfer(1'b0, RRN_OFS_STATUS, 32'h0, v);
		if (lgl == 1)
			flags = ((res == 0) << 4) | ((res >> 7) << 3);
		if (lgl == 1)
			check("status", v, flags | 2);
		else
			check("status", v & 32'h1d, flags | 4);
		rd_chk("wreg", RRN_OFS_WREG, (lgl == 1) ? ((d == 0) ? res : wreg) : (wreg ^ 255));
		rd_chk("file", RRN_OFS_MDATA, (lgl == 1 && d == 1) ? res : fb);
		rd_chk("ctrl", RRN_OFS_CTRL, ext * 2);
	endtask : run_op

	// watchdog sized well above the expected run of about 2200 cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end

	// main sequence
	initial
	begin
		int f;
		int a;
		void'($urandom(32'h35d7));
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		// registers clear after reset, unmapped places read zero
		for (int o = 0; o < 28; o += 4)
			if (o != 20)
				rd_chk("reset", 8'(o), 32'h0);
		rd_chk("status_rst", RRN_OFS_STATUS, 32'h0);
		rd_chk("unmapped", 8'h20, 32'h0);
		rd_chk("unmapped", 8'hfc, 32'h0);
		// only byte lanes with sel set take new data
		sel_mask = 4'he;
		wr(RRN_OFS_WREG, 32'h0000_00a5);
		rd_chk("sel_off", RRN_OFS_WREG, 32'h0);
		sel_mask = 4'h1;
		wr(RRN_OFS_WREG, 32'h0000_00a5);
		sel_mask = 4'hf;
		rd_chk("sel_on", RRN_OFS_WREG, 32'h0000_00a5);
		// access-bank boundaries first, then random operands
		for (int i = 0; i < 40; i++)
		begin
			f = (i < 6) ? f_tab[i] : $urandom_range(255);
			a = (i < 6) ? 0 : $urandom_range(1);
			run_op(16384 + $urandom_range(1) * 512 + a * 256 + f, i % 2, $urandom_range(15),
				$urandom_range(4095), $urandom_range(255), (i % 7 == 3) ? 0 : $urandom_range(255));
		end
		// neighbouring encodings must be refused
		run_op(32'h4400 + $urandom_range(1023), 0, 1, 0, 8'h5a, 8'h81);
		run_op(32'h3000 + $urandom_range(1023), 1, 2, 3, 8'h3c, 8'h01);
		stop_test();
	end
endmodule : rotate_right_no_carry_exec_bench
